// File: verilog/rsp_pkg.sv
// Purpose : Shared constants and types of the radio serial slave port.
// Assumes : Serial mode 0 (clock idles low, sample on rising edge).
// Notes   : Control byte layout and indirect window addresses live here.
package rsp_pkg;

  // ****************************************************************
  // Control byte layout
  // ****************************************************************
  localparam int CW_RD_BIT  = 7;            // 1 = read, 0 = write.
  localparam int CW_BUF_BIT = 6;            // 1 = packet buffer, 0 = register.
  localparam int REG_AW     = 6;            // Direct register address width.
  localparam int IND_AW     = 8;            // Indirect index width.
  localparam int PB_AW      = 7;            // Packet buffer address width.
  localparam int DW         = 8;            // Byte width.

  // ****************************************************************
  // Sizes and special addresses
  // ****************************************************************
  localparam int PB_DEPTH   = 128;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W     = 1 + PB_AW + DW;
  localparam logic [REG_AW-1:0] IND_INDEX_ADDR = 6'h3e;
  localparam logic [REG_AW-1:0] IND_DATA_ADDR  = 6'h3f;
  localparam logic [2:0]        LAST_BIT       = 3'h7;
  localparam logic [2:0]        FIRST_BIT      = 3'h0;
  localparam logic [DW-1:0]     IDLE_FILL      = 8'h00;
  localparam logic [PB_AW-1:0]  LEN_ADDR       = 7'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int WR_SCLK_MAX_MHZ  = 16;
  localparam int RD_SCLK_MAX_MHZ  = 9;
  // Core cycles in half a read bit; the read answer must land inside it.
  localparam int RD_HALF_BIT_CYC  = CLK_MHZ / (2 * RD_SCLK_MAX_MHZ);

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} rsp_phase_e;
  typedef enum logic [1:0] {RD_IDLE, RD_PEND, RD_REG} rsp_rd_e;

endpackage

// File: verilog/rsp_async_fifo.sv
// Purpose : Dual-clock FIFO carrying serial write bytes to the core clock.
// Assumes : DEPTH is a power of two, at least four.
// Notes   : Gray pointers cross each way; flags are conservative.
`timescale 1ns/1ps
`default_nettype none
module rsp_async_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             wclk_i,
  input  wire logic             wrst_i,
  input  wire logic             w_valid_i,
  input  wire logic [WIDTH-1:0] w_data_i,
  output logic                  w_ready_o,
  input  wire logic             rclk_i,
  input  wire logic             rrst_i,
  output logic                  r_valid_o,
  output logic      [WIDTH-1:0] r_data_o,
  input  wire logic             r_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg;
  logic [AW:0]      wgray_reg;
  logic [AW:0]      rg_s1_reg;
  logic [AW:0]      rg_s2_reg;
  logic [AW:0]      rbin_reg;
  logic [AW:0]      rgray_reg;
  logic [AW:0]      wg_s1_reg;
  logic [AW:0]      wg_s2_reg;
  logic [AW:0]      wbin_next;
  logic [AW:0]      rbin_next;
  logic             push;
  logic             pop;

  // ****************************************************************
  // Flags and pointer arithmetic
  // ****************************************************************
  // Full is seen from a stale read pointer, so it may linger, never lie.
  assign w_ready_o = wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
  assign r_valid_o = rgray_reg != wg_s2_reg;
  assign push      = w_valid_i && w_ready_o;
  assign pop       = r_valid_o && r_ready_i;
  assign wbin_next = wbin_reg + (AW+1)'(push);
  assign rbin_next = rbin_reg + (AW+1)'(pop);
  assign r_data_o  = mem[rbin_reg[AW-1:0]];

  // Storage is written on the filling clock only.
  always_ff @(posedge wclk_i) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= w_data_i;
    end
  end

  // Write side; its clock may stop, so reset acts without it.
  always_ff @(posedge wclk_i or posedge wrst_i) begin
    if (wrst_i) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  // Read side on the core clock.
  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule
`default_nettype wire

// File: verilog/rsp_port.sv
// Purpose : Serial slave port giving a host access to radio registers
//           and to the shared packet buffer.
// Assumes : Mode 0 framing; the serial clock is a clock of its own.
// Notes   : Reads are answered by the core within half a serial bit.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Slave only; host drives select, clock, data.
// - Register reads and writes, single or burst.
// - Buffer reads and writes, single or burst.
// - No timing relation assumed to serial clock.
// - Both directions cross domains inside the port.
// - Works in every power mode except reset.
// - Hibernate keeps buffer and the indirect index reachable.
// - Every access opens with a control byte.
// - First byte returns primary interrupt status.
// - Bursts auto-increment the target address.
// - Whole buffer moves in one burst.
// - 128-byte shared buffer, length at address zero.
// - Guard blocks receive writes, not host writes.
module rsp_port #(
  parameter int PB_DEPTH   = rsp_pkg::PB_DEPTH,
  parameter int FIFO_DEPTH = rsp_pkg::FIFO_DEPTH
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic                       spi_sclk_i,
  input  wire logic                       spi_sel_n_i,
  input  wire logic                       spi_mosi_i,
  output logic                            spi_miso_o,
  output logic                            spi_miso_oe_n_o,
  input  wire logic [rsp_pkg::DW-1:0]     primary_irq_status_i,
  input  wire logic                       xtal_off_i,
  input  wire logic                       buffer_overwrite_guard_i,
  input  wire logic                       rx_pb_wr_valid_i,
  input  wire logic [rsp_pkg::PB_AW-1:0]  rx_pb_wr_addr_i,
  input  wire logic [rsp_pkg::DW-1:0]     rx_pb_wr_data_i,
  input  wire logic [rsp_pkg::PB_AW-1:0]  tx_pb_rd_addr_i,
  output logic      [rsp_pkg::DW-1:0]     tx_pb_rd_data_o,
  output logic      [rsp_pkg::DW-1:0]     frame_len_o,
  output logic                            reg_wr_valid_o,
  output logic                            reg_wr_ind_o,
  output logic      [rsp_pkg::IND_AW-1:0] reg_wr_addr_o,
  output logic      [rsp_pkg::DW-1:0]     reg_wr_data_o,
  output logic                            reg_rd_ind_o,
  output logic      [rsp_pkg::IND_AW-1:0] reg_rd_addr_o,
  input  wire logic [rsp_pkg::DW-1:0]     reg_rd_data_i,
  output logic                            spi_overrun_o
);

  // ****************************************************************
  // Serial clock domain
  // ****************************************************************
  logic [2:0]                  bit_cnt_reg;
  logic [6:0]                  rx_reg;
  rsp_pkg::rsp_phase_e         phase_reg;
  logic                        rd_reg;
  logic                        buf_reg;
  logic [rsp_pkg::PB_AW-1:0]   addr_reg;
  logic                        req_tgl_reg;
  logic [rsp_pkg::PB_AW-1:0]   req_addr_reg;
  logic                        req_buf_reg;
  logic                        ovr_tgl_reg;
  logic                        first_reg;
  logic [rsp_pkg::DW-1:0]      tx_reg;

  // Core clock domain state that the serial side reads as held data.
  logic [rsp_pkg::DW-1:0]      status_snap_reg;
  logic [rsp_pkg::DW-1:0]      rd_data_reg;

  logic [rsp_pkg::DW-1:0]      byte_in;
  logic                        byte_done;
  logic                        cw_rd;
  logic                        cw_buf;
  logic [rsp_pkg::PB_AW-1:0]   cw_addr;
  logic [rsp_pkg::PB_AW-1:0]   addr_inc;
  logic                        reg_at_window;
  logic                        wr_push;
  logic                        rd_issue;
  logic [rsp_pkg::PB_AW-1:0]   issue_addr;
  logic                        issue_buf;
  logic [rsp_pkg::DW-1:0]      load_byte;
  logic                        fifo_wr_ready;

  // Byte assembly and control byte decode.
  assign byte_in       = {rx_reg, spi_mosi_i};
  assign byte_done     = bit_cnt_reg == rsp_pkg::LAST_BIT;
  assign cw_rd         = byte_in[rsp_pkg::CW_RD_BIT];
  assign cw_buf        = byte_in[rsp_pkg::CW_BUF_BIT];
  assign cw_addr       = {1'b0, byte_in[rsp_pkg::REG_AW-1:0]};
  assign reg_at_window = addr_reg[rsp_pkg::REG_AW-1:0] == rsp_pkg::IND_DATA_ADDR;

  // Buffer addresses wrap over the full buffer; the indirect data window
  // stays put so a burst walks the indirect index instead.
  assign addr_inc = buf_reg ? rsp_pkg::PB_AW'(addr_reg + 7'h01) :
                    reg_at_window ? addr_reg :
                    {1'b0, rsp_pkg::REG_AW'(addr_reg[rsp_pkg::REG_AW-1:0] + 6'h01)};

  // Write bytes leave through the FIFO; read addresses leave as a toggle.
  assign wr_push    = byte_done && (phase_reg == rsp_pkg::PH_DATA) && !rd_reg;
  assign rd_issue   = byte_done && (((phase_reg == rsp_pkg::PH_CMD) && cw_rd && !cw_buf) ||
                                    ((phase_reg != rsp_pkg::PH_CMD) && rd_reg));
  assign issue_addr = (phase_reg == rsp_pkg::PH_CMD)  ? cw_addr :
                      (phase_reg == rsp_pkg::PH_ADDR) ? byte_in[rsp_pkg::PB_AW-1:0] : addr_inc;
  assign issue_buf  = (phase_reg == rsp_pkg::PH_CMD) ? cw_buf : buf_reg;
  assign load_byte  = ((phase_reg == rsp_pkg::PH_DATA) && rd_reg) ? rd_data_reg : rsp_pkg::IDLE_FILL;

  // Receive side; deselect clears everything, so a partial byte is lost.
  always_ff @(posedge spi_sclk_i or posedge spi_sel_n_i) begin
    if (spi_sel_n_i) begin
      bit_cnt_reg <= rsp_pkg::FIRST_BIT;
      rx_reg      <= '0;
      phase_reg   <= rsp_pkg::PH_CMD;
      rd_reg      <= 1'b0;
      buf_reg     <= 1'b0;
      addr_reg    <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= byte_in[6:0];
      if (byte_done) begin
        case (phase_reg)
          rsp_pkg::PH_CMD: begin
            rd_reg    <= cw_rd;
            buf_reg   <= cw_buf;
            addr_reg  <= cw_addr;
            phase_reg <= cw_buf ? rsp_pkg::PH_ADDR : rsp_pkg::PH_DATA;
          end
          rsp_pkg::PH_ADDR: begin
            addr_reg  <= byte_in[rsp_pkg::PB_AW-1:0];
            phase_reg <= rsp_pkg::PH_DATA;
          end
          rsp_pkg::PH_DATA: begin
            addr_reg  <= addr_inc;
          end
          default: begin
            phase_reg <= rsp_pkg::PH_CMD;
          end
        endcase
      end
    end
  end

  // Event toggles outlive the frame, so only the port reset clears them.
  always_ff @(posedge spi_sclk_i or posedge srst_i) begin
    if (srst_i) begin
      req_tgl_reg  <= 1'b0;
      req_addr_reg <= '0;
      req_buf_reg  <= 1'b0;
      ovr_tgl_reg  <= 1'b0;
    end else begin
      if (rd_issue) begin
        req_tgl_reg  <= ~req_tgl_reg;
        req_addr_reg <= issue_addr;
        req_buf_reg  <= issue_buf;
      end
      if (wr_push && !fifo_wr_ready) begin
        ovr_tgl_reg <= ~ovr_tgl_reg;
      end
    end
  end

  // Transmit side shifts on the falling edge; the status byte goes first.
  always_ff @(negedge spi_sclk_i or posedge spi_sel_n_i) begin
    if (spi_sel_n_i) begin
      first_reg <= 1'b1;
      tx_reg    <= '0;
    end else begin
      first_reg <= 1'b0;
      if (first_reg) begin
        tx_reg <= {status_snap_reg[6:0], 1'b0};
      end else if (bit_cnt_reg == rsp_pkg::FIRST_BIT) begin
        tx_reg <= load_byte;
      end else begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // The first status bit must show before any clock edge, so it is picked
  // from the frozen snapshot rather than from the shifter.
  assign spi_miso_o = first_reg ? status_snap_reg[rsp_pkg::DW-1] : tx_reg[rsp_pkg::DW-1];

  // ****************************************************************
  // Crossing FIFO for write bytes
  // ****************************************************************
  logic                        fifo_rd_valid;
  logic                        fifo_rd_ready;
  logic [rsp_pkg::FIFO_W-1:0]  fifo_rd_data;

  rsp_async_fifo #(
    .WIDTH (rsp_pkg::FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .wclk_i    (spi_sclk_i),
    .wrst_i    (srst_i),
    .w_valid_i (wr_push),
    .w_data_i  ({buf_reg, addr_reg, byte_in}),
    .w_ready_o (fifo_wr_ready),
    .rclk_i    (clk_i),
    .rrst_i    (srst_i),
    .r_valid_o (fifo_rd_valid),
    .r_data_o  (fifo_rd_data),
    .r_ready_i (fifo_rd_ready)
  );

  // ****************************************************************
  // Core clock domain
  // ****************************************************************
  logic                         sel_s1_reg;
  logic                         sel_s2_reg;
  logic                         req_s1_reg;
  logic                         req_s2_reg;
  logic                         req_s3_reg;
  logic                         ovr_s1_reg;
  logic                         ovr_s2_reg;
  logic                         ovr_s3_reg;
  rsp_pkg::rsp_rd_e             rd_st_reg;
  logic [rsp_pkg::IND_AW-1:0]   ind_idx_reg;
  logic [rsp_pkg::DW-1:0]       pb_mem [PB_DEPTH];

  logic                         req_pulse;
  logic                         f_buf;
  logic [rsp_pkg::PB_AW-1:0]    f_addr;
  logic [rsp_pkg::DW-1:0]       f_data;
  logic                         f_is_index;
  logic                         f_is_window;
  logic                         rq_is_index;
  logic                         rq_is_window;
  logic                         rx_we;
  logic                         host_pb_we;
  logic                         pb_we;
  logic [rsp_pkg::PB_AW-1:0]    pb_waddr;
  logic [rsp_pkg::DW-1:0]       pb_wdata;
  logic                         reg_drain;
  logic                         read_now;

  // Field split of the FIFO head and of the pending read request.
  assign f_buf        = fifo_rd_data[rsp_pkg::FIFO_W-1];
  assign f_addr       = fifo_rd_data[rsp_pkg::DW +: rsp_pkg::PB_AW];
  assign f_data       = fifo_rd_data[rsp_pkg::DW-1:0];
  assign f_is_index   = f_addr[rsp_pkg::REG_AW-1:0] == rsp_pkg::IND_INDEX_ADDR;
  assign f_is_window  = f_addr[rsp_pkg::REG_AW-1:0] == rsp_pkg::IND_DATA_ADDR;
  assign rq_is_index  = req_addr_reg[rsp_pkg::REG_AW-1:0] == rsp_pkg::IND_INDEX_ADDR;
  assign rq_is_window = req_addr_reg[rsp_pkg::REG_AW-1:0] == rsp_pkg::IND_DATA_ADDR;
  assign req_pulse    = req_s2_reg ^ req_s3_reg;

  // Receive frames own the write port when unguarded; host buffer bytes then
  // wait in the FIFO, which is what lets it fill.
  assign rx_we         = rx_pb_wr_valid_i && !buffer_overwrite_guard_i;
  assign fifo_rd_ready = fifo_rd_valid && !(f_buf && rx_we);
  assign host_pb_we    = fifo_rd_ready && f_buf;
  assign reg_drain     = fifo_rd_ready && !f_buf;
  assign pb_we         = rx_we || host_pb_we;
  assign pb_waddr      = rx_we ? rx_pb_wr_addr_i : f_addr;
  assign pb_wdata      = rx_we ? rx_pb_wr_data_i : f_data;
  // Reads wait for earlier writes so a read never overtakes them.
  assign read_now      = (rd_st_reg == rsp_pkg::RD_PEND) && !fifo_rd_valid;

  // Synchronisers: select level, read request toggle, overrun toggle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_s1_reg <= 1'b1;
      sel_s2_reg <= 1'b1;
      {req_s1_reg, req_s2_reg, req_s3_reg} <= 3'h0;
      {ovr_s1_reg, ovr_s2_reg, ovr_s3_reg} <= 3'h0;
    end else begin
      sel_s1_reg <= spi_sel_n_i;
      sel_s2_reg <= sel_s1_reg;
      {req_s1_reg, req_s2_reg, req_s3_reg} <= {req_tgl_reg, req_s1_reg, req_s2_reg};
      {ovr_s1_reg, ovr_s2_reg, ovr_s3_reg} <= {ovr_tgl_reg, ovr_s1_reg, ovr_s2_reg};
    end
  end

  // Status is sampled only while deselected and held through the access.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status_snap_reg <= '0;
      spi_miso_oe_n_o <= 1'b1;
      spi_overrun_o   <= 1'b0;
    end else begin
      if (sel_s2_reg) begin
        status_snap_reg <= primary_irq_status_i;
      end
      spi_miso_oe_n_o <= sel_s2_reg;
      spi_overrun_o   <= ovr_s2_reg ^ ovr_s3_reg;
    end
  end

  // Packet buffer: shared by receive frames, transmit and the host.
  always_ff @(posedge clk_i) begin
    if (pb_we) begin
      pb_mem[pb_waddr] <= pb_wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_pb_rd_data_o <= '0;
      frame_len_o     <= '0;
    end else begin
      tx_pb_rd_data_o <= pb_mem[tx_pb_rd_addr_i];
      frame_len_o     <= pb_mem[rsp_pkg::LEN_ADDR];
    end
  end

  // Register writes. In hibernate the gated side drops direct and window writes,
  // while the buffer and the index stay usable.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_wr_valid_o <= 1'b0;
      reg_wr_ind_o   <= 1'b0;
      reg_wr_addr_o  <= '0;
      reg_wr_data_o  <= '0;
    end else begin
      reg_wr_valid_o <= reg_drain && !f_is_index && !xtal_off_i;
      reg_wr_ind_o   <= f_is_window;
      reg_wr_addr_o  <= f_is_window ? ind_idx_reg : rsp_pkg::IND_AW'(f_addr);
      reg_wr_data_o  <= f_data;
    end
  end

  // Indirect index: set through its own address, stepped by each window
  // access so that a burst sweeps the indirect space.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ind_idx_reg <= '0;
    end else if (reg_drain && f_is_index) begin
      ind_idx_reg <= f_data;
    end else if ((reg_drain && f_is_window) || (read_now && !req_buf_reg && rq_is_window)) begin
      ind_idx_reg <= ind_idx_reg + 8'h01;
    end
  end

  // Read server. The answer must settle within half a serial bit, which
  // the read clock limit guarantees for this path.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_st_reg     <= rsp_pkg::RD_IDLE;
      rd_data_reg   <= '0;
      reg_rd_ind_o  <= 1'b0;
      reg_rd_addr_o <= '0;
    end else begin
      case (rd_st_reg)
        rsp_pkg::RD_IDLE: begin
          if (req_pulse) begin
            rd_st_reg <= rsp_pkg::RD_PEND;
          end
        end
        rsp_pkg::RD_PEND: begin
          if (read_now) begin
            if (req_buf_reg) begin
              rd_data_reg <= pb_mem[req_addr_reg];
              rd_st_reg   <= rsp_pkg::RD_IDLE;
            end else if (rq_is_index) begin
              rd_data_reg <= ind_idx_reg;
              rd_st_reg   <= rsp_pkg::RD_IDLE;
            end else if (xtal_off_i) begin
              rd_data_reg <= rsp_pkg::IDLE_FILL;
              rd_st_reg   <= rsp_pkg::RD_IDLE;
            end else begin
              reg_rd_ind_o  <= rq_is_window;
              reg_rd_addr_o <= rq_is_window ? ind_idx_reg : rsp_pkg::IND_AW'(req_addr_reg);
              rd_st_reg     <= rsp_pkg::RD_REG;
            end
          end
        end
        rsp_pkg::RD_REG: begin
          rd_data_reg <= reg_rd_data_i;
          rd_st_reg   <= rsp_pkg::RD_IDLE;
        end
        default: begin
          rd_st_reg <= rsp_pkg::RD_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: bench/rsp_port_checker.sv
// Purpose: Pin-level assertions for rsp_port.
// Assumes: Select is sampled on clk_i.
// Notes: The enable trails select by three flops, so windows span 1 to 4 clk.
`timescale 1ns/1ps
`default_nettype none
module rsp_port_checker (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       spi_sel_n_i,
  input wire logic       spi_miso_o,
  input wire logic       spi_miso_oe_n_o,
  input wire logic       xtal_off_i,
  input wire logic       reg_wr_valid_o,
  input wire logic       reg_wr_ind_o,
  input wire logic [7:0] reg_wr_addr_o,
  input wire logic [7:0] frame_len_o,
  input wire logic [7:0] primary_irq_status_i,
  input wire logic       spi_overrun_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_sel_drop;
    $fell(spi_sel_n_i);
  endsequence
  sequence s_sel_rise;
    $rose(spi_sel_n_i);
  endsequence
  a_reset_ctrl_idle: assert property ($fell(srst_i) |-> spi_miso_oe_n_o && !reg_wr_valid_o && !spi_overrun_o)
    else $error("control outputs busy after reset");
  a_reset_data_zero: assert property ($fell(srst_i) |-> frame_len_o == 8'h00 && reg_wr_addr_o == 8'h00)
    else $error("data outputs not cleared by reset");
  a_oe_on_select: assert property (s_sel_drop |-> ##[1:4] (!spi_miso_oe_n_o || spi_sel_n_i))
    else $error("data out not enabled after select");
  a_oe_off_release: assert property (s_sel_rise |-> ##[1:4] (spi_miso_oe_n_o || !spi_sel_n_i))
    else $error("data out still enabled after release");
  a_oe_idle_high: assert property (spi_sel_n_i [*4] |-> spi_miso_oe_n_o)
    else $error("data out enabled while idle");
  a_miso_idle_status: assert property (spi_sel_n_i [*4] |-> spi_miso_o == $past(primary_irq_status_i[7]))
    else $error("data out differs from status while idle");
  a_hib_wr_block: assert property (xtal_off_i [*8] |-> !reg_wr_valid_o || reg_wr_addr_o == 8'h3e)
    else $error("register write passed in hibernate");
  a_direct_addr_range: assert property (reg_wr_valid_o && !reg_wr_ind_o |-> reg_wr_addr_o[7:6] == 2'b00)
    else $error("direct write address out of range");
endmodule
bind rsp_port rsp_port_checker chk_u (.clk_i, .srst_i, .spi_sel_n_i, .spi_miso_o, .spi_miso_oe_n_o, .xtal_off_i,
  .reg_wr_valid_o, .reg_wr_ind_o, .reg_wr_addr_o, .frame_len_o, .primary_irq_status_i, .spi_overrun_o);
`default_nettype wire

// File: bench/rsp_host_model.sv
// Purpose: Host master driving the serial port, mode 0.
// Assumes: Only one caller process at a time.
// Notes: The serial clock stands low outside frames.
`timescale 1ns/1ps
`default_nettype none
module rsp_host_model (
  output logic     sclk_o,
  output logic     sel_n_o,
  output logic     mosi_o,
  input wire logic miso_i
);
  // 8 MHz stays under both ceilings.
  localparam realtime HALF = 62.5;
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // The pause after select lets the port freeze its status byte.
  task automatic open_frame();
    sel_n_o = 1'b0;
    #40;
  endtask
  // Released data is inverted, not held.
  task automatic close_frame();
    #60;
    sel_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #100;
  endtask
  // Data is set after a falling edge and the answer taken on the rising one.
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = tx[i];
      #HALF sclk_o = 1'b1;
      rx = {rx[6:0], miso_i};
      #HALF sclk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: bench/rsp_port_tb.sv
// Purpose: Self-checking bench for rsp_port.
// Assumes: Radio read data is the address xor 5a, or xor da for indirect reads.
// Notes: Buffer bytes hold their address xor 33.
`timescale 1ns/1ps
`default_nettype none
module rsp_port_tb;
  logic        clk_i = 1'b0, srst_i = 1'b1, xtal_off_i = 1'b0;
  logic        buffer_overwrite_guard_i = 1'b0, rx_pb_wr_valid_i = 1'b0;
  logic [6:0]  rx_pb_wr_addr_i = 7'h05, tx_pb_rd_addr_i = 7'h00;
  logic [7:0]  rx_pb_wr_data_i = 8'hee, primary_irq_status_i = 8'ha7;
  logic [7:0]  tx_pb_rd_data_o, frame_len_o, reg_wr_addr_o, reg_wr_data_o, reg_rd_addr_o;
  logic        spi_miso_o, spi_miso_oe_n_o, reg_wr_valid_o, reg_wr_ind_o, reg_rd_ind_o, spi_overrun_o;
  wire logic   spi_sclk_i, spi_sel_n_i, spi_mosi_i;
  wire logic   miso_line = spi_miso_oe_n_o ? 1'bz : spi_miso_o;
  wire logic [7:0] reg_rd_data_i = reg_rd_addr_o ^ {reg_rd_ind_o, 7'h5a};
  logic [15:0] wr_last = 16'h0000, wr_cnt = 16'h0000, ovr_cnt = 16'h0000;
  int          miscompares = 0, checks = 0;
  // ****
  // Clock, models and the port
  // ****
  always #2 clk_i = ~clk_i;
  rsp_port dut_u (.*);
  rsp_host_model host_u (.sclk_o(spi_sclk_i), .sel_n_o(spi_sel_n_i), .mosi_o(spi_mosi_i), .miso_i(miso_line));
  // Counters of what the radio side sees.
  always_ff @(posedge clk_i) begin
    if (reg_wr_valid_o) wr_cnt <= wr_cnt + 16'h0001;
    if (reg_wr_valid_o) wr_last <= {reg_wr_addr_o, reg_wr_data_o};
    if (spi_overrun_o) ovr_cnt <= ovr_cnt + 16'h0001;
  end
  // ****
  // Helpers
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic xb(input logic [7:0] tx, input logic [7:0] exp);
    logic [7:0] got;
    host_u.shift(tx, 8, got);
    check({8'h00, got}, {8'h00, exp});
  endtask
  // Sample one clk after the data register has had its edge.
  task automatic peek(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk_i) tx_pb_rd_addr_i <= a;
    repeat (2) @(posedge clk_i);
    #1 check({8'h00, tx_pb_rd_data_o}, {8'h00, exp});
  endtask
  task automatic reg_access(input logic [7:0] ctl, input logic [7:0] d, input logic [7:0] exp);
    host_u.open_frame();
    xb(ctl, primary_irq_status_i);
    xb(d, exp);
  endtask
  task automatic buf_fill(input logic [6:0] a, input int n);
    reg_access(8'h40, {1'b0, a}, 8'h00);
    for (int i = 0; i < n; i++) xb({1'b0, a + 7'(i)} ^ 8'h33, 8'h00);
    host_u.close_frame();
  endtask
  task automatic buf_read(input logic [6:0] a, input int n);
    logic [7:0] junk;
    host_u.open_frame();
    xb(8'hc0, primary_irq_status_i);
    host_u.shift({1'b0, a}, 8, junk);
    for (int i = 0; i < n; i++) xb(8'h00, {1'b0, a + 7'(i)} ^ 8'h33);
    host_u.close_frame();
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reg();
    reg_access(8'h85, 8'h00, 8'h5f);
    xb(8'h00, 8'h5c);
    host_u.close_frame();
    reg_access(8'h10, 8'h3c, 8'h00);
    xb(8'hc3, 8'h00);
    host_u.close_frame();
    check(wr_last, 16'h11c3);
    check(wr_cnt, 16'h0002);
    reg_access(8'h3e, 8'h80, 8'h00);
    host_u.close_frame();
    reg_access(8'h3f, 8'h11, 8'h00);
    xb(8'h22, 8'h00);
    host_u.close_frame();
    check(wr_last, 16'h8122);
    reg_access(8'hbf, 8'h00, 8'h58);
    host_u.close_frame();
    $display("reg test done");
  endtask
  // A half byte before release must not skew the next frame.
  task automatic t_partial();
    logic [7:0] junk;
    host_u.open_frame();
    host_u.shift(8'hff, 4, junk);
    host_u.close_frame();
    reg_access(8'h85, 8'h00, 8'h5f);
    host_u.close_frame();
    $display("partial test done");
  endtask
  task automatic t_buf();
    @(posedge clk_i) buffer_overwrite_guard_i <= 1'b1;
    buf_fill(7'h00, 128);
    @(posedge clk_i) rx_pb_wr_valid_i <= 1'b1;
    @(posedge clk_i) rx_pb_wr_valid_i <= 1'b0;
    check({8'h00, frame_len_o}, 16'h0033);
    peek(7'h05, 8'h36);
    buf_read(7'h7e, 4);
    $display("buffer test done");
  endtask
  task automatic t_hib();
    @(posedge clk_i) xtal_off_i <= 1'b1;
    reg_access(8'h10, 8'h99, 8'h00);
    host_u.close_frame();
    check(wr_cnt, 16'h0004);
    reg_access(8'h85, 8'h00, 8'h00);
    host_u.close_frame();
    buf_read(7'h05, 1);
    @(posedge clk_i) xtal_off_i <= 1'b0;
    $display("hibernate test done");
  endtask
  // Receive writes hog the buffer port, so the FIFO fills and refuses.
  task automatic t_ovr();
    @(posedge clk_i) buffer_overwrite_guard_i <= 1'b0;
    @(posedge clk_i) rx_pb_wr_valid_i <= 1'b1;
    buf_fill(7'h20, 24);
    @(posedge clk_i) rx_pb_wr_valid_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    check(ovr_cnt, 16'h0008);
    peek(7'h05, 8'hee);
    peek(7'h20, 8'h13);
    $display("overrun test done");
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    t_reg();
    t_partial();
    t_buf();
    t_hib();
    t_ovr();
    complete_run();
  end
  // Tests take about 200 us; a hang is cut off well past that.
  initial begin
    #300000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
